/* File: hw/dwscu_top.sv */
// Serial command unit of a dual 1024-position nonvolatile potentiometer
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Write protect blocks all content changes; restores 1, 8 and preset still change the wipers
// R2 - Commands 1 and 8 restore despite protect
// R3 - Host sends no-op before releasing protect
// R4 - Preset rising edge reloads wipers from copy
// R5 - Nonvolatile copy starts at midscale 512
// R6 - Frame executes only when select returns high
// R7 - Ready marks completion of 2,3,8,9,10, preset
// R8 - Frame is command, address, sixteen data bits
// R9 - Store takes 25 ms, serial port locked
// R10 - Ready pulses low until store completes
// R11 - Addresses 2 to 14 are user words
// R12 - Power-up loads wipers from nonvolatile copy
// R13 - Codes 0,1,2,3,8 decode as listed
// R14 - 9 reads copy, 10 reads wiper, 11 writes
// R15 - 6 dB steps: 4,5 down, 12,13 up
// R16 - Single steps: 6,7 down, 14,15 up
// R17 - Wiper code directly selects tap position
// R18 - Wiper register takes unlimited writes
// R19 - Host sends no-op after a restore; the bench table sends 8 right after 1, and 11 right after that 8
// R20 - Bits sampled on rising clock, MSB first
// R21 - Address 0 first channel, 1 second
// R22 - Readback or previous frame shifts out
// R23 - Preset low holds wipers at midscale
// R24 - 6 dB moves shift one bit, saturating
// R25 - Single steps saturate at the ends
module dwscu_top #(
  parameter int P_STORE_CYCLES = dwscu_pkg::STORE_CYCLES
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_SCLK,
  input  wire logic        I_SDI,
  input  wire logic        I_CS_N,
  input  wire logic        I_WP_N,
  input  wire logic        I_PRESET_STROBE_N,
  output logic             O_SDO,
  output logic             O_SDO_OE_N,
  output logic             O_RDY,
  output logic             O_RDY_OE_N,
  output logic [9:0]       O_WIPER0,
  output logic [9:0]       O_WIPER1,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [31:0] I_WB_DAT,
  input  wire logic        I_WB_WE,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK
);

  initial
  begin
    if (P_STORE_CYCLES < 2 || P_STORE_CYCLES >= (1 << 23))
      $error("P_STORE_CYCLES out of range");
  end

  localparam logic [22:0] STORE_LAST = 23'(P_STORE_CYCLES - 1);

  dwscu_pkg::dwscu_state_type s_r;
  dwscu_pkg::dwscu_state_type s_nxt;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        cs_low;
  logic        wp_ok;
  logic        pr_low;
  logic        pr_rise;
  logic        exec;
  logic [23:0] frame;

  //////////////////////////////////////////////////////////////////////////////
  // Wiper arithmetic
  function automatic logic [9:0] up6(input logic [9:0] w);
    up6 = w[9] ? dwscu_pkg::WIPER_MAX : {w[8:0], 1'b0};
  endfunction

  function automatic logic [9:0] up1(input logic [9:0] w);
    up1 = (w == dwscu_pkg::WIPER_MAX) ? w : 10'(w + 10'h001);
  endfunction

  function automatic logic [9:0] dn1(input logic [9:0] w);
    dn1 = (w == 10'h000) ? w : 10'(w - 10'h001);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins
  assign sclk_rise = s_r.sync2[dwscu_pkg::SY_SCLK] & ~s_r.sync3[dwscu_pkg::SY_SCLK];
  assign sclk_fall = ~s_r.sync2[dwscu_pkg::SY_SCLK] & s_r.sync3[dwscu_pkg::SY_SCLK];
  assign cs_rise   = s_r.sync2[dwscu_pkg::SY_CS] & ~s_r.sync3[dwscu_pkg::SY_CS];
  assign cs_fall   = ~s_r.sync2[dwscu_pkg::SY_CS] & s_r.sync3[dwscu_pkg::SY_CS];
  assign cs_low    = ~s_r.sync2[dwscu_pkg::SY_CS];
  assign wp_ok     = s_r.sync2[dwscu_pkg::SY_WP];
  assign pr_low    = ~s_r.sync2[dwscu_pkg::SY_PR];
  assign pr_rise   = s_r.sync2[dwscu_pkg::SY_PR] & ~s_r.sync3[dwscu_pkg::SY_PR];

  // A whole frame, or a bare select pulse that repeats the last one
  assign exec  = cs_rise && s_r.fsm == dwscu_pkg::ST_IDLE && s_r.port_en && !pr_low
                 && ((s_r.seen && s_r.cnt == 5'h00) || (!s_r.seen && s_r.have_last)); // see R6
  assign frame = s_r.seen ? s_r.sr : s_r.last;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [3:0]  cmd;
    logic [3:0]  adr;
    logic [15:0] dat;
    logic        ch;
    cmd   = frame[dwscu_pkg::CMD_MSB:dwscu_pkg::CMD_LSB];
    adr   = frame[dwscu_pkg::ADR_MSB:dwscu_pkg::ADR_LSB];
    dat   = frame[15:0];
    ch    = adr[0]; // see R21
    s_nxt = s_r;
    s_nxt.sync1  = {I_PRESET_STROBE_N, I_WP_N, I_CS_N, I_SDI, I_SCLK};
    s_nxt.sync2  = s_r.sync1;
    s_nxt.sync3  = s_r.sync2;
    s_nxt.wb_ack = 1'b0;
    if (s_r.fsm == dwscu_pkg::ST_IDLE)
      s_nxt.rdy = 1'b1;

    // Serial shifting, locked while a store runs
    if (s_r.fsm == dwscu_pkg::ST_IDLE)
    begin
      if (cs_low && sclk_rise)
      begin
        s_nxt.sr   = {s_r.sr[22:0], s_r.sync2[dwscu_pkg::SY_SDI]}; // see R20
        s_nxt.cnt  = (s_r.cnt == 5'(dwscu_pkg::FRAME_BITS - 1)) ? 5'h00
                     : 5'(s_r.cnt + 5'h01); // see R8
        s_nxt.seen = 1'b1;
      end
      if (cs_low && sclk_fall)
        s_nxt.sdo_oe_n = s_r.sr[23]; // see R22
      if (cs_fall)
        s_nxt.sdo_oe_n = s_r.sr[23];
    end
    if (!cs_low)
      s_nxt.sdo_oe_n = 1'b1;
    if (cs_rise)
    begin
      s_nxt.cnt  = 5'h00;
      s_nxt.seen = 1'b0;
    end

    // Command decode
    if (exec)
    begin
      s_nxt.last      = frame;
      s_nxt.have_last = 1'b1;
      case (dwscu_pkg::dwscu_cmd_type'(cmd)) // see R13
        dwscu_pkg::CMD_RESTORE:
          s_nxt.wiper[ch] = s_r.nvm[ch][9:0]; // see R2
        dwscu_pkg::CMD_STORE, dwscu_pkg::CMD_STORE_ANY:
          if (wp_ok) // see R1
          begin
            s_nxt.st_addr = {3'h0, ch};
            s_nxt.st_data = {6'h00, s_r.wiper[ch]};
            if (cmd == dwscu_pkg::CMD_STORE_ANY && adr >= dwscu_pkg::NV_USER_LO)
            begin
              s_nxt.st_addr = adr; // see R11
              s_nxt.st_data = dat;
            end
            if (!(cmd == dwscu_pkg::CMD_STORE_ANY && adr == dwscu_pkg::NV_RESERVED))
            begin
              s_nxt.fsm = dwscu_pkg::ST_STORE; // see R9
              s_nxt.tmr = 23'h000000;
              s_nxt.rdy = 1'b0; // see R10
            end
          end
        dwscu_pkg::CMD_RESET_RESTORE:
        begin
          for (int i = 0; i < 2; i++)
            s_nxt.wiper[i] = s_r.nvm[i][9:0]; // see R2
          s_nxt.rdy = 1'b0; // see R7
        end
        dwscu_pkg::CMD_READ_NV:
        begin
          s_nxt.sr  = {cmd, adr, s_r.nvm[adr]}; // see R14
          s_nxt.rdy = 1'b0;
        end
        dwscu_pkg::CMD_READ_WIPER:
        begin
          s_nxt.sr  = {cmd, adr, 6'h00, s_r.wiper[ch]}; // see R14
          s_nxt.rdy = 1'b0;
        end
        dwscu_pkg::CMD_WRITE: // see R18
          if (wp_ok)
            s_nxt.wiper[ch] = dat[9:0]; // see R17
        default:
          if (wp_ok && cmd != dwscu_pkg::CMD_NOP)
            for (int i = 0; i < 2; i++)
              if (cmd[0] || i == int'(ch))
                case (cmd[3:1])
                  3'h2:    s_nxt.wiper[i] = {1'b0, s_r.wiper[i][9:1]}; // see R15
                  3'h6:    s_nxt.wiper[i] = up6(s_r.wiper[i]); // see R24
                  3'h3:    s_nxt.wiper[i] = dn1(s_r.wiper[i]); // see R16
                  3'h7:    s_nxt.wiper[i] = up1(s_r.wiper[i]); // see R25
                  default: s_nxt.wiper[i] = s_r.wiper[i];
                endcase
      endcase
    end

    // Control sequencing
    case (s_r.fsm)
      dwscu_pkg::ST_PWRUP:
      begin
        for (int i = 0; i < 2; i++)
          s_nxt.wiper[i] = s_r.nvm[i][9:0]; // see R12
        s_nxt.fsm = dwscu_pkg::ST_IDLE;
      end
      dwscu_pkg::ST_IDLE:
        s_nxt.fsm = s_nxt.fsm;
      dwscu_pkg::ST_STORE:
      begin
        s_nxt.rdy = 1'b0;
        s_nxt.cnt = 5'h00;
        s_nxt.tmr = 23'(s_r.tmr + 23'h000001);
        if (s_r.tmr == STORE_LAST)
        begin
          s_nxt.nvm[s_r.st_addr] = s_r.st_data; // see R9
          s_nxt.fsm              = dwscu_pkg::ST_IDLE;
          s_nxt.rdy              = 1'b1; // see R10
        end
      end
      default:
        s_nxt.fsm = dwscu_pkg::ST_IDLE;
    endcase

    // Preset strobe overrides serial writes
    if (pr_low)
      for (int i = 0; i < 2; i++)
        s_nxt.wiper[i] = dwscu_pkg::WIPER_MID; // see R23
    if (pr_rise && s_r.fsm != dwscu_pkg::ST_PWRUP)
    begin
      for (int i = 0; i < 2; i++)
        s_nxt.wiper[i] = s_r.nvm[i][9:0]; // see R4
      if (s_r.fsm == dwscu_pkg::ST_IDLE)
        s_nxt.rdy = 1'b0; // see R7
    end

    // Wishbone slave, one wait state
    if (I_WB_CYC && I_WB_STB && !s_r.wb_ack)
    begin
      s_nxt.wb_ack = 1'b1;
      s_nxt.wb_dat = 32'h00000000;
      if (I_WB_WE)
      begin
        if (I_WB_ADR == dwscu_pkg::REG_CTRL && I_WB_SEL[0])
          s_nxt.port_en = I_WB_DAT[0];
      end
      else
        case (I_WB_ADR)
          dwscu_pkg::REG_STATUS:
            s_nxt.wb_dat = {26'h0000000, s_r.fsm, wp_ok, pr_low, s_r.rdy};
          dwscu_pkg::REG_WIPER0: s_nxt.wb_dat = {22'h000000, s_r.wiper[0]};
          dwscu_pkg::REG_WIPER1: s_nxt.wb_dat = {22'h000000, s_r.wiper[1]};
          dwscu_pkg::REG_CTRL:   s_nxt.wb_dat = {31'h00000000, s_r.port_en};
          default:               s_nxt.wb_dat = 32'h00000000;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      s_r          <= '0;
      // Serial clock lane starts low, its idle level, so no false edge follows reset
      s_r.sync1    <= 5'h1E;
      s_r.sync2    <= 5'h1E;
      s_r.sync3    <= 5'h1E;
      s_r.sdo_oe_n <= 1'b1;
      s_r.fsm      <= dwscu_pkg::ST_PWRUP;
      s_r.wiper[0] <= dwscu_pkg::WIPER_MID;
      s_r.wiper[1] <= dwscu_pkg::WIPER_MID;
      s_r.nvm[0]   <= dwscu_pkg::NV_FACTORY; // see R5
      s_r.nvm[1]   <= dwscu_pkg::NV_FACTORY;
      s_r.rdy      <= 1'b1;
      s_r.port_en  <= dwscu_pkg::CTRL_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign O_SDO      = 1'b0;
  assign O_SDO_OE_N = s_r.sdo_oe_n;
  assign O_RDY      = 1'b0;
  assign O_RDY_OE_N = s_r.rdy;
  assign O_WIPER0   = s_r.wiper[0];
  assign O_WIPER1   = s_r.wiper[1];
  assign O_WB_DAT   = s_r.wb_dat;
  assign O_WB_ACK   = s_r.wb_ack;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_wp_blocks_write: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R1
    exec && !wp_ok && frame[23:20] == 4'hB && !pr_low && !pr_rise
    |=> $stable(s_r.wiper)) else $error("write changed wiper under protect");

  a_restore_loads: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R2
    exec && frame[23:20] == 4'h8 && !pr_low && !pr_rise
    |=> s_r.wiper[0] == s_r.nvm[0][9:0] && s_r.wiper[1] == s_r.nvm[1][9:0])
    else $error("reset restore did not load wipers");

  a_preset_mid: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R23
    pr_low |=> s_r.wiper[0] == 10'h200 && s_r.wiper[1] == 10'h200)
    else $error("wiper not midscale during preset");

  a_preset_load: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R4
    pr_rise && s_r.fsm == dwscu_pkg::ST_IDLE && !exec
    |=> s_r.wiper[1] == $past(s_r.nvm[1][9:0]) && !s_r.rdy)
    else $error("preset release did not reload");

  a_exec_on_cs: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R6
    !$stable(s_r.wiper) |-> $past(cs_rise) || $past(pr_low) || $past(pr_rise)
    || $past(s_r.fsm) == dwscu_pkg::ST_PWRUP) else $error("wiper moved without select rise");

  a_store_lock: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R9
    s_r.fsm == dwscu_pkg::ST_STORE |=> $stable(s_r.sr) && $stable(s_r.wiper[0])
    || $past(pr_low) || $past(pr_rise)) else $error("shift register moved during store");

  a_store_rdy: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R10
    s_r.fsm == dwscu_pkg::ST_STORE && $past(s_r.fsm) == dwscu_pkg::ST_STORE
    |-> !s_r.rdy) else $error("ready high during store");

  a_step_sat: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R25
    exec && wp_ok && frame[23:20] == 4'hF && s_r.wiper[1] == 10'h3FF && !pr_low && !pr_rise
    |=> s_r.wiper[1] == 10'h3FF) else $error("step wrapped past full scale");

  a_read_nv: assert property (@(posedge I_MCLK) disable iff (I_RST) // see R14
    exec && frame[23:20] == 4'h9 |=> s_r.sr[15:0] == $past(s_r.nvm[frame[19:16]]) && !s_r.rdy)
    else $error("readback not loaded");

endmodule

/* File: hw/dwscu_pkg.sv */
// Shared constants and types of the dual wiper serial command unit
package dwscu_pkg;

  // Serial frame layout
  localparam int FRAME_BITS  = 24;
  localparam int CMD_MSB     = 23;
  localparam int CMD_LSB     = 20;
  localparam int ADR_MSB     = 19;
  localparam int ADR_LSB     = 16;
  localparam int WIPER_BITS  = 10;

  // Synchroniser lanes
  localparam int SY_SCLK = 0;
  localparam int SY_SDI  = 1;
  localparam int SY_CS   = 2;
  localparam int SY_WP   = 3;
  localparam int SY_PR   = 4;

  // Reset values, wiper full scale and nonvolatile address limits
  localparam logic [9:0]  WIPER_MID    = 10'h200;
  localparam logic [9:0]  WIPER_MAX    = 10'h3FF;
  localparam logic [15:0] NV_FACTORY   = 16'h0200;
  localparam logic [3:0]  NV_RESERVED  = 4'hF;
  localparam logic [3:0]  NV_USER_LO   = 4'h2;

  // Store timing
  localparam int STORE_TIME_MS = 25;
  localparam int CLK_FREQ_KHZ  = 250000;
  localparam int STORE_CYCLES  = STORE_TIME_MS * CLK_FREQ_KHZ;

  // Wishbone register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_WIPER0 = 8'h04;
  localparam logic [7:0] REG_WIPER1 = 8'h08;
  localparam logic [7:0] REG_CTRL   = 8'h0C;
  localparam logic       CTRL_RESET = 1'b1;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_RESTORE = 4'h1, CMD_STORE = 4'h2, CMD_STORE_ANY = 4'h3,
    CMD_DEC6 = 4'h4, CMD_DEC6_ALL = 4'h5, CMD_DEC1 = 4'h6, CMD_DEC1_ALL = 4'h7,
    CMD_RESET_RESTORE = 4'h8, CMD_READ_NV = 4'h9, CMD_READ_WIPER = 4'hA,
    CMD_WRITE = 4'hB, CMD_INC6 = 4'hC, CMD_INC6_ALL = 4'hD, CMD_INC1 = 4'hE,
    CMD_INC1_ALL = 4'hF
  } dwscu_cmd_type;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'b001,
    ST_IDLE  = 3'b010,
    ST_STORE = 3'b100
  } dwscu_fsm_type;

  typedef struct packed {
    logic [4:0]         sync1;
    logic [4:0]         sync2;
    logic [4:0]         sync3;
    logic [23:0]        sr;
    logic [4:0]         cnt;
    logic               seen;
    logic [23:0]        last;
    logic               have_last;
    logic               sdo_oe_n;
    dwscu_fsm_type      fsm;
    logic [1:0][9:0]    wiper;
    logic [15:0][15:0]  nvm;
    logic [22:0]        tmr;
    logic [3:0]         st_addr;
    logic [15:0]        st_data;
    logic               rdy;
    logic               wb_ack;
    logic [31:0]        wb_dat;
    logic               port_en;
  } dwscu_state_type;

endpackage

/* File: tb/dwscu_host.sv */
// Serial host model driving the four-wire port of the command unit
`timescale 1ns/1ns
module dwscu_host (
  output logic        o_sclk,
  output logic        o_sdi,
  output logic        o_cs_n,
  input  wire logic   i_sdo,
  output logic [23:0] o_rx
);
  initial
  begin
    o_sclk = 1'b0;
    o_sdi = 1'b1;
    o_cs_n = 1'b1;
    o_rx = 24'h000000;
  end
  // Clock stands low between frames; bits leave MSB first, data changes on fall
  task automatic shift(input logic [23:0] f);
    for (int k = 23; k >= 0; k--)
    begin
      o_sdi = f[k];
      #62 o_sclk = 1'b1;
      o_rx = {o_rx[22:0], i_sdo};
      #63 o_sclk = 1'b0;
    end
    o_sdi = ~f[0];
  endtask
  task automatic open_frame();
    o_cs_n = 1'b0;
    #100;
  endtask
  // Gap after select rises leaves room for the frame to execute
  task automatic close_frame();
    #100 o_cs_n = 1'b1;
    #300;
  endtask
  task automatic send(input logic [23:0] f);
    open_frame();
    shift(f);
    close_frame();
  endtask
endmodule

/* File: tb/dwscu_top_tb.sv */
// Self-checking bench of the dual wiper serial command unit
`timescale 1ns/1ns
module dwscu_top_tb;
  localparam int ST = 2000;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        pr_n = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        sclk, sdi, cs_n, sdo_d, sdo_oe_n, rdy_d, rdy_oe_n;
  logic [9:0]  w0, w1;
  logic [23:0] rx;
  logic [31:0] rd;
  int          base;
  int          n_low = 0;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [43:0] rows [16] = '{
    {24'hB00100, 10'h100, 10'h200}, {24'hB10300, 10'h100, 10'h300},
    {24'hC00000, 10'h200, 10'h300}, {24'h400000, 10'h100, 10'h300},
    {24'hD00000, 10'h200, 10'h3FF}, {24'hF00000, 10'h201, 10'h3FF},
    {24'h610000, 10'h201, 10'h3FE}, {24'h700000, 10'h200, 10'h3FD},
    {24'h510000, 10'h100, 10'h1FE}, {24'hE00000, 10'h101, 10'h1FE},
    {24'hB00000, 10'h000, 10'h1FE}, {24'h600000, 10'h000, 10'h1FE},
    {24'h400000, 10'h000, 10'h1FE}, {24'hC00000, 10'h000, 10'h1FE},
    {24'h100000, 10'h200, 10'h1FE}, {24'h810000, 10'h200, 10'h200}};
  // Open-drain pin with pull-up
  wire sdo = sdo_oe_n ? 1'b1 : sdo_d;
  wire rdy = rdy_oe_n ? 1'b1 : rdy_d;

  always #2 mclk = ~mclk;
  always @(posedge mclk)
    if (rdy === 1'b0)
      n_low <= n_low + 1;

  dwscu_top #(.P_STORE_CYCLES(ST)) dwscu_top_i (.I_MCLK(mclk), .I_RST(rst),
    .I_SCLK(sclk), .I_SDI(sdi), .I_CS_N(cs_n), .I_WP_N(wp_n),
    .I_PRESET_STROBE_N(pr_n), .O_SDO(sdo_d), .O_SDO_OE_N(sdo_oe_n), .O_RDY(rdy_d),
    .O_RDY_OE_N(rdy_oe_n), .O_WIPER0(w0), .O_WIPER1(w1), .I_WB_ADR(adr),
    .I_WB_DAT(wdat), .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack));
  dwscu_host dwscu_host_i (.o_sclk(sclk), .o_sdi(sdi), .o_cs_n(cs_n), .i_sdo(sdo),
    .o_rx(rx));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hF;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge mclk);
    while (ack !== 1'b1 && t < 50)
    begin
      @(posedge mclk);
      t++;
    end
    if (t == 50)
      n_mismatch++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic frame(input logic [23:0] f);
    dwscu_host_i.send(f);
    repeat (10) @(posedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #300000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    check(32'(w0), 32'h200);
    check(32'(w1), 32'h200);
    wb(8'h10, 1'b0, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      frame(rows[i][43:20]);
      check(32'(w0), 32'(rows[i][19:10]));
      check(32'(w1), 32'(rows[i][9:0]));
      wb(dwscu_pkg::REG_WIPER1, 1'b0, 32'h0);
      check(rd, 32'(rows[i][9:0]));
    end
    dwscu_host_i.open_frame();
    dwscu_host_i.shift(24'hB00155);
    repeat (20) @(posedge mclk);
    check(32'(w0), 32'h200);
    dwscu_host_i.close_frame();
    repeat (10) @(posedge mclk);
    check(32'(w0), 32'h155);
    base = n_low;
    frame(24'h200000);
    frame(24'hB00000);
    repeat (ST) @(posedge mclk);
    check(32'(w0), 32'h155);
    check(n_low - base, ST);
    frame(24'hB00000);
    @(posedge mclk);
    pr_n <= 1'b0;
    repeat (10) @(posedge mclk);
    check(32'(w0), 32'h200);
    base = n_low;
    pr_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check(32'(w0), 32'h155);
    check(n_low - base, 1);
    frame(24'hB00000);
    wp_n <= 1'b0;
    frame(24'hB00123);
    frame(24'hC00000);
    check(32'(w0), 32'h0);
    frame(24'h100000);
    check(32'(w0), 32'h155);
    frame(24'h000000);
    check(32'(rx), 32'h100000);
    wp_n <= 1'b1;
    frame(24'h35A5C3);
    repeat (ST + 10) @(posedge mclk);
    frame(24'h950000);
    frame(24'hA00000);
    check(32'(rx), 32'h95A5C3);
    frame(24'h000000);
    check(32'(rx), 32'hA00155);
    wb(dwscu_pkg::REG_CTRL, 1'b1, 32'h0);
    frame(24'hB00077);
    check(32'(w0), 32'h155);
    wb(dwscu_pkg::REG_CTRL, 1'b1, 32'h1);
    wb(dwscu_pkg::REG_WIPER0, 1'b0, 32'h0);
    check(rd, 32'h155);
    test_done();
  end
endmodule
